// >>> common/cmp_ctrl_pkg.sv
// shared constants, field layout and carrier types of the comparator control block
`default_nettype none
package cmp_ctrl_pkg;

  // ==========================================================================
  // register byte offsets on the bus
  localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFS_IRQ_STATUS = 32'h0000_0004;
  localparam logic [31:0] OFS_IRQ_MASK = 32'h0000_0008;

  // ==========================================================================
  // comparator_status_control field positions
  localparam int BIT_ENABLE = 7;
  localparam int BIT_REF_SEL = 6;
  localparam int BIT_FLAG = 5;
  localparam int BIT_IRQ_EN = 4;
  localparam int BIT_RESULT = 3;
  localparam int BIT_PIN_EN = 2;
  localparam int MODE_MSB = 1;
  localparam int MODE_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // event_mode_select codes
  localparam logic [1:0] MODE_FALL_A = 2'h0;
  localparam logic [1:0] MODE_RISE = 2'h1;
  localparam logic [1:0] MODE_FALL_B = 2'h2;
  localparam logic [1:0] MODE_BOTH = 2'h3;

  // ==========================================================================
  // sticky interrupt status and mask layout
  localparam int IRQ_W = 3;
  localparam int IRQ_EVENT = 0;
  localparam int IRQ_RISE = 1;
  localparam int IRQ_FALL = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // ==========================================================================
  // bus encodings and widths
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  localparam int SAMPLE_W = 10;

  // sync and edge detector fill count
  localparam logic [1:0] FILL_DONE = 2'h3;

  // digitised analog levels seen by the comparator
  typedef struct packed {
    logic [SAMPLE_W-1:0] positive_input_pin;
    logic [SAMPLE_W-1:0] negative_input_pin;
    logic [SAMPLE_W-1:0] bandgap_level;
  } analog_in_t;

  // low power and debug state of the processor
  typedef struct packed {
    logic wait_mode;
    logic light_stop_mode;
    logic deep_stop_mode_one;
    logic deep_stop_mode_two;
    logic debug_halt;
  } power_mode_t;

  // latched address phase of a bus transfer
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } bus_phase_t;

endpackage
`default_nettype wire

// >>> logic/result_sync.sv
// two-stage synchroniser and edge detector for the comparator result
`timescale 1ns/100ps
`default_nettype none
module result_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic raw,
  input wire logic freeze,
  input wire logic clear,
  output logic level,
  output logic rise,
  output logic fall
);
  import cmp_ctrl_pkg::*;

  logic s1_q;
  logic s2_q;
  logic prev_q;
  logic clear_q;
  logic [1:0] fill_q;

  // the decision register still holds its disabled zero one edge after enabling,
  // so the pipeline stays empty for that edge too, or enabling would fake an edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clear_q <= 1'b1;
    end else begin
      clear_q <= clear;
    end
  end

  // ==========================================================================
  // sampling; frozen while clocks are halted, emptied while disabled
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      prev_q <= 1'b0;
      fill_q <= 2'h0;
    end else if (clear || clear_q) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      prev_q <= 1'b0;
      fill_q <= 2'h0;
    end else if (!freeze) begin
      s1_q <= raw;
      s2_q <= s1_q;
      prev_q <= s2_q;
      if (fill_q != FILL_DONE) begin
        fill_q <= fill_q + 2'h1;
      end
    end
  end

  // edges only once prev holds a real sample, so enabling never fakes one
  assign level = s2_q;
  assign rise = (fill_q == FILL_DONE) && !freeze && s2_q && !prev_q;
  assign fall = (fill_q == FILL_DONE) && !freeze && !s2_q && prev_q;

endmodule
`default_nettype wire

// >>> logic/analog_comparator_control.sv
// register, event and power-mode control around the analog comparator
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module analog_comparator_control (
  input wire logic mclk,
  input wire logic rst,
  // bus slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // analog core and system
  input wire cmp_ctrl_pkg::analog_in_t analog_in,
  input wire cmp_ctrl_pkg::power_mode_t power_mode,
  output logic comparator_output_pin,
  output logic result_pin_oe_n,
  output logic cmp_irq
);
  import cmp_ctrl_pkg::*;

  // ==========================================================================
  // declarations
  bus_phase_t dphase_q;
  logic [31:0] rdata_q;
  logic comparator_enable_q;
  logic reference_select_q;
  logic compare_event_flag_q;
  logic compare_irq_enable_q;
  logic result_pin_enable_q;
  logic [1:0] event_mode_select_q;
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic raw_q;
  logic raw_d;
  logic pin_q;
  logic pin_oe_n_q;
  logic [SAMPLE_W-1:0] plus_in;
  logic [SAMPLE_W-1:0] minus_in;
  logic any_stop;
  logic deep_stop;
  logic active;
  logic addr_take;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic sync_level;
  logic sync_rise;
  logic sync_fall;
  logic cmp_event;
  logic result_bit;
  logic [7:0] ctrl_view;
  logic [IRQ_W-1:0] irq_events;

  // ==========================================================================
  // power modes: wait and debug halt change nothing, stop disables the core
  // wait_mode and debug_halt are deliberately ignored
  assign any_stop = power_mode.light_stop_mode | power_mode.deep_stop_mode_one | power_mode.deep_stop_mode_two;
  assign deep_stop = power_mode.deep_stop_mode_one | power_mode.deep_stop_mode_two;
  assign active = comparator_enable_q && !any_stop;

  // ==========================================================================
  // comparator decision on digitised levels
  assign plus_in = reference_select_q ? analog_in.bandgap_level : analog_in.positive_input_pin;
  assign minus_in = analog_in.negative_input_pin;

  // equal levels hold the last decision, standing in for the analog hysteresis
  always_comb begin
    raw_d = raw_q;
    if (!active) begin
      raw_d = 1'b0;
    end else if (plus_in > minus_in) begin
      raw_d = 1'b1;
    end else if (plus_in < minus_in) begin
      raw_d = 1'b0;
    end
  end

  // decision register; frozen with the clocks in light stop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      raw_q <= 1'b0;
    end else if (deep_stop) begin
      raw_q <= 1'b0;
    end else if (!power_mode.light_stop_mode) begin
      raw_q <= raw_d;
    end
  end

  // ==========================================================================
  // synchroniser and edge detector
  result_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .raw(raw_q),
    .freeze(power_mode.light_stop_mode),
    .clear(!comparator_enable_q || deep_stop),
    .level(sync_level),
    .rise(sync_rise),
    .fall(sync_fall)
  );

  // event selection by mode; no events while any stop mode holds
  always_comb begin
    cmp_event = 1'b0;
    case (event_mode_select_q)
      MODE_FALL_A: cmp_event = sync_fall;
      MODE_RISE: cmp_event = sync_rise;
      MODE_FALL_B: cmp_event = sync_fall;
      MODE_BOTH: cmp_event = sync_rise | sync_fall;
      default: cmp_event = 1'b0;
    endcase
    if (!active) begin
      cmp_event = 1'b0;
    end
  end

  assign irq_events = {sync_fall & active, sync_rise & active, cmp_event};
  assign result_bit = active ? sync_level : 1'b0;

  // ==========================================================================
  // bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = rdata_q;
  assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign wr_ctrl = dphase_q.valid && dphase_q.write && (dphase_q.addr == OFS_CTRL);
  assign wr_status = dphase_q.valid && dphase_q.write && (dphase_q.addr == OFS_IRQ_STATUS);
  assign wr_mask = dphase_q.valid && dphase_q.write && (dphase_q.addr == OFS_IRQ_MASK);

  // address phase latch; hsize is always a word here
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dphase_q <= '0;
    end else if (hready) begin
      dphase_q.valid <= addr_take;
      dphase_q.write <= hwrite;
      dphase_q.addr <= haddr;
    end
  end

  // register view as software reads it
  always_comb begin
    ctrl_view = CTRL_RESET;
    ctrl_view[BIT_ENABLE] = comparator_enable_q;
    ctrl_view[BIT_REF_SEL] = reference_select_q;
    ctrl_view[BIT_FLAG] = compare_event_flag_q;
    ctrl_view[BIT_IRQ_EN] = compare_irq_enable_q;
    ctrl_view[BIT_RESULT] = result_bit;
    ctrl_view[BIT_PIN_EN] = result_pin_enable_q;
    ctrl_view[MODE_MSB:MODE_LSB] = event_mode_select_q;
  end

  // read data captured at the address phase, unmapped words read zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= RDATA_ZERO;
    end else if (addr_take && !hwrite) begin
      if (haddr == OFS_CTRL) begin
        rdata_q <= {24'h00_0000, ctrl_view};
      end else if (haddr == OFS_IRQ_STATUS) begin
        rdata_q <= {29'h0000_0000, irq_status_q};
      end else if (haddr == OFS_IRQ_MASK) begin
        rdata_q <= {29'h0000_0000, irq_mask_q};
      end else begin
        rdata_q <= RDATA_ZERO;
      end
    end
  end

  // ==========================================================================
  // control fields; deep stop returns them to reset, light stop holds them
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      comparator_enable_q <= CTRL_RESET[BIT_ENABLE];
      reference_select_q <= CTRL_RESET[BIT_REF_SEL];
      compare_irq_enable_q <= CTRL_RESET[BIT_IRQ_EN];
      result_pin_enable_q <= CTRL_RESET[BIT_PIN_EN];
      event_mode_select_q <= CTRL_RESET[MODE_MSB:MODE_LSB];
    end else if (deep_stop) begin
      comparator_enable_q <= CTRL_RESET[BIT_ENABLE];
      reference_select_q <= CTRL_RESET[BIT_REF_SEL];
      compare_irq_enable_q <= CTRL_RESET[BIT_IRQ_EN];
      result_pin_enable_q <= CTRL_RESET[BIT_PIN_EN];
      event_mode_select_q <= CTRL_RESET[MODE_MSB:MODE_LSB];
    end else if (wr_ctrl) begin
      comparator_enable_q <= hwdata[BIT_ENABLE];
      reference_select_q <= hwdata[BIT_REF_SEL];
      compare_irq_enable_q <= hwdata[BIT_IRQ_EN];
      result_pin_enable_q <= hwdata[BIT_PIN_EN];
      event_mode_select_q <= hwdata[MODE_MSB:MODE_LSB];
    end
  end

  // event flag: a new event beats a clearing write in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      compare_event_flag_q <= CTRL_RESET[BIT_FLAG];
    end else if (deep_stop) begin
      compare_event_flag_q <= CTRL_RESET[BIT_FLAG];
    end else if (cmp_event) begin
      compare_event_flag_q <= 1'b1;
    end else if (wr_ctrl && hwdata[BIT_FLAG]) begin
      compare_event_flag_q <= 1'b0;
    end
  end

  // sticky status, write one to clear, set wins; mask is plain storage
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_status_q <= IRQ_RESET;
      irq_mask_q <= IRQ_RESET;
    end else if (deep_stop) begin
      irq_status_q <= IRQ_RESET;
      irq_mask_q <= IRQ_RESET;
    end else begin
      irq_status_q <= irq_events | (irq_status_q & ~(wr_status ? hwdata[IRQ_W-1:0] : IRQ_RESET));
      if (wr_mask) begin
        irq_mask_q <= hwdata[IRQ_W-1:0];
      end
    end
  end

  // interrupt level; stays readable from held state through light stop
  assign cmp_irq = (compare_irq_enable_q && compare_event_flag_q) || (|(irq_status_q & irq_mask_q));

  // ==========================================================================
  // output pin, registered; enable low while the block drives it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end else begin
      pin_q <= result_pin_enable_q && result_bit;
      pin_oe_n_q <= !result_pin_enable_q;
    end
  end

  assign comparator_output_pin = pin_q;
  assign result_pin_oe_n = pin_oe_n_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  chk_flag_on_event: assert property (cmp_event && !deep_stop |=> compare_event_flag_q)
    else $error("event did not set the flag");
  chk_flag_write_clear: assert property (wr_ctrl && hwdata[BIT_FLAG] && !cmp_event && !deep_stop
    |=> !compare_event_flag_q)
    else $error("write one did not clear the flag");
  chk_flag_write_zero: assert property (wr_ctrl && !hwdata[BIT_FLAG] && compare_event_flag_q && !deep_stop
    |=> compare_event_flag_q)
    else $error("write zero cleared the flag");
  chk_irq_gate: assert property (irq_mask_q == IRQ_RESET |-> cmp_irq == (compare_irq_enable_q && compare_event_flag_q))
    else $error("interrupt not gated by enable");
  chk_result_off: assert property (!active |-> !ctrl_view[BIT_RESULT])
    else $error("result visible while disabled");
  chk_pin_follow: assert property (result_pin_enable_q && !deep_stop && !wr_ctrl
    |=> comparator_output_pin == $past(result_bit) && !result_pin_oe_n)
    else $error("pin does not follow result");
  chk_compare_high: assert property (active && !power_mode.light_stop_mode && plus_in > minus_in |=> raw_q)
    else $error("compare not high");
  chk_stop_no_event: assert property (any_stop |-> !cmp_event && irq_events == IRQ_RESET)
    else $error("event during stop");
  chk_deep_reset: assert property (deep_stop |=> !comparator_enable_q && !compare_event_flag_q
    && event_mode_select_q == CTRL_RESET[MODE_MSB:MODE_LSB])
    else $error("deep stop left state");
  chk_light_hold: assert property (power_mode.light_stop_mode && !deep_stop && !dphase_q.valid
    ##1 power_mode.light_stop_mode |-> $stable(ctrl_view) && $stable(raw_q))
    else $error("light stop changed state");
  chk_mode_rise: assert property (event_mode_select_q == MODE_RISE && cmp_event |-> sync_rise)
    else $error("rising mode took other edge");

  cov_flag_irq: cover property (compare_irq_enable_q && compare_event_flag_q ##1 wr_ctrl);
  cov_both_edges: cover property (event_mode_select_q == MODE_BOTH && sync_fall && cmp_event);
  cov_light_resume: cover property (power_mode.light_stop_mode && comparator_enable_q ##1 !any_stop && active);
  cov_pin_high: cover property (comparator_output_pin && !result_pin_oe_n);

endmodule
`default_nettype wire

// >>> test/analog_model.sv
// behavioural analog front end feeding digitised levels to the comparator control
`timescale 1ns/100ps
`default_nettype none
module analog_model (
  input wire logic plus_high,
  input wire logic bg_high,
  input wire logic [cmp_ctrl_pkg::SAMPLE_W-1:0] minus_lvl,
  output var cmp_ctrl_pkg::analog_in_t analog_in
);
  import cmp_ctrl_pkg::*;
  // levels sit one step either side of the minus input; a tie would hold state and hide an edge
  always_comb begin
    analog_in.negative_input_pin = minus_lvl;
    analog_in.positive_input_pin = plus_high ? minus_lvl + 10'h001 : minus_lvl - 10'h001;
    analog_in.bandgap_level = bg_high ? minus_lvl + 10'h001 : minus_lvl - 10'h001;
  end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the comparator control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import cmp_ctrl_pkg::*;
  logic mclk, rst, hsel, hwrite, hready, hreadyout, hresp, pin, oe_n, irq;
  logic plus_high, bg_high, rise;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, md;
  logic [2:0] hsize;
  logic [SAMPLE_W-1:0] minus_lvl;
  analog_in_t analog_in;
  power_mode_t power_mode;
  logic [31:0] exp_q[$], seen_q[$];
  int n_fail, total_checks;

  // ==========================================================================
  // clock, design and analog partner
  always #50 mclk = ~mclk;
  assign hready = hreadyout;
  analog_comparator_control u_analog_comparator_control (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .analog_in(analog_in),
    .power_mode(power_mode), .comparator_output_pin(pin), .result_pin_oe_n(oe_n),
    .cmp_irq(irq));
  analog_model u_analog_model (
    .plus_high(plus_high), .bg_high(bg_high), .minus_lvl(minus_lvl), .analog_in(analog_in));

  // ==========================================================================
  // bus master: address phase held until hready, then data phase until hready
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1 && ++n < 99);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1 && ++n < 99);
    r = hrdata;
  endtask
  // a write is given one more edge so that its effect has landed before sampling
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
    @(posedge mclk);
  endtask
  task automatic rd(input logic [31:0] a, e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    note(r, e);
    note({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask
  task automatic note(input logic [31:0] got, e);
    seen_q.push_back(got);
    exp_q.push_back(e);
  endtask
  task automatic wt();
    repeat (8) @(posedge mclk);
  endtask
  function automatic logic [31:0] pio();
    return {29'h0, pin, oe_n, irq};
  endfunction
  function automatic logic [31:0] ctl(input logic en, rs, fl, ie, res, pe, input logic [1:0] m);
    return {24'h0, en, rs, fl, ie, res, pe, m};
  endfunction

  // ==========================================================================
  // scoreboard: oldest observation against oldest expectation
  task automatic check(input logic [31:0] got, e);
    total_checks++;
    if (got !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, got, e);
    end
  endtask
  initial begin
    forever begin
      wait (seen_q.size() > 0);
      check(seen_q.pop_front(), exp_q.pop_front());
    end
  end

  task automatic end_of_test();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(20000 * 100);
    n_fail++;
    end_of_test();
  end

  // ==========================================================================
  // main sequence
  initial begin
    mclk = 0;
    rst = 1;
    hsel = 0;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hsize = 3'h2;
    hwdata = 0;
    power_mode = '0;
    plus_high = 0;
    bg_high = 0;
    minus_lvl = 10'h200;
    n_fail = 0;
    total_checks = 0;
    void'($urandom(79));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    // reset values and an unmapped word
    rd(OFS_CTRL, {24'h0, CTRL_RESET});
    rd(OFS_IRQ_STATUS, 32'h0);
    rd(OFS_IRQ_MASK, 32'h0);
    rd(32'h0000_0010, RDATA_ZERO);
    note(pio(), 32'h2);
    // every event mode, run with wait and debug halt asserted
    power_mode.wait_mode <= 1'b1;
    power_mode.debug_halt <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      md = 2'(m);
      rise = (md == MODE_RISE) || (md == MODE_BOTH);
      minus_lvl <= 10'(1 + $urandom_range(1020));
      wr(OFS_CTRL, ctl(1, 0, 1, 1, 0, 1, md));
      wt();
      wr(OFS_CTRL, ctl(1, 0, 1, 1, 0, 1, md));
      plus_high <= 1'b1;
      wt();
      rd(OFS_CTRL, ctl(1, 0, rise, 1, 1, 1, md));
      note(pio(), {29'h0, 2'h2, rise});
      wr(OFS_CTRL, ctl(1, 0, 0, 1, 0, 1, md));
      rd(OFS_CTRL, ctl(1, 0, rise, 1, 1, 1, md));
      wr(OFS_CTRL, ctl(1, 0, 1, 0, 0, 1, md));
      plus_high <= 1'b0;
      wt();
      rd(OFS_CTRL, ctl(1, 0, md != MODE_RISE, 0, 0, 1, md));
      note(pio(), 32'h0);
    end
    // sticky status raised, masked and cleared
    wr(OFS_IRQ_STATUS, 32'h7);
    wr(OFS_IRQ_MASK, 32'h1);
    plus_high <= 1'b1;
    wt();
    rd(OFS_IRQ_STATUS, 32'h3);
    note(pio(), 32'h5);
    wr(OFS_IRQ_MASK, 32'h0);
    note(pio(), 32'h4);
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_IRQ_STATUS, 32'h1);
    rd(OFS_IRQ_STATUS, 32'h2);
    note(pio(), 32'h4);
    // bandgap on the plus side while the pin level stays low
    plus_high <= 1'b0;
    wt();
    wr(OFS_CTRL, ctl(1, 1, 1, 0, 0, 0, MODE_RISE));
    bg_high <= 1'b1;
    wt();
    rd(OFS_CTRL, ctl(1, 1, 1, 0, 1, 0, MODE_RISE));
    // light stop freezes state and ignores edges; clearing light_stop_mode resumes
    power_mode.light_stop_mode <= 1'b1;
    bg_high <= 1'b0;
    wt();
    rd(OFS_CTRL, ctl(1, 1, 1, 0, 0, 0, MODE_RISE));
    wr(OFS_CTRL, ctl(1, 1, 1, 0, 0, 0, MODE_RISE));
    bg_high <= 1'b1;
    wt();
    rd(OFS_CTRL, ctl(1, 1, 0, 0, 0, 0, MODE_RISE));
    power_mode.light_stop_mode <= 1'b0;
    wt();
    rd(OFS_CTRL, ctl(1, 1, 0, 0, 1, 0, MODE_RISE));
    // not wanted as a wake source in wait, so switched off
    wr(OFS_CTRL, ctl(0, 0, 1, 1, 0, 1, MODE_BOTH));
    plus_high <= 1'b1;
    wt();
    rd(OFS_CTRL, ctl(0, 0, 0, 1, 0, 1, MODE_BOTH));
    // deep stop modes leave the reset state behind
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CTRL, ctl(1, 0, 0, 1, 0, 1, MODE_BOTH));
      wr(OFS_IRQ_MASK, 32'h5);
      rd(OFS_CTRL, ctl(1, 0, 0, 1, 1, 1, MODE_BOTH));
      power_mode.deep_stop_mode_one <= (k == 0);
      power_mode.deep_stop_mode_two <= (k == 1);
      repeat (3) @(posedge mclk);
      power_mode.deep_stop_mode_one <= 1'b0;
      power_mode.deep_stop_mode_two <= 1'b0;
      rd(OFS_CTRL, {24'h0, CTRL_RESET});
      rd(OFS_IRQ_MASK, 32'h0);
      note(pio(), 32'h2);
    end
    // reset while in light stop
    wr(OFS_CTRL, ctl(1, 0, 0, 1, 0, 1, MODE_RISE));
    power_mode.light_stop_mode <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    power_mode.light_stop_mode <= 1'b0;
    rd(OFS_CTRL, {24'h0, CTRL_RESET});
    repeat (2) @(posedge mclk);
    end_of_test();
  end
endmodule
`default_nettype wire
